// [cwd_option_decoder.v]
// configuration word loader and option decoder
//
// What this block does
// - upper device options half is user identifier
// - options bit 3: one normal, zero high drive
// - debug field picks pin pair or none
// - debug bit 2 enables boundary-scan port
// - power bit 3 enables low-power detector when main one off
// - power bit 2 disables retention regulator
// - brownout 11: always on, software ignored
// - brownout 10: on awake, off asleep
// - 01 software decides, 00 always off
// - watchdog bit 15 enables watchdog
// - run clock: 11 low-power, 10 fast, 00 system
// - run postscale power of two, saturating
// - sleep watchdog clock is low-power oscillator
// - watchdog bit 7 zero enables window mode
// - window size 25, 37.5, 50, 75 percent
// - sleep postscale same encoding, saturating
`timescale 1ns/10ps
`default_nettype none
`include "cwd_defines.vh"

module cwd_option_decoder #(
   parameter ADDR_W = 8
) (
   // clock and reset
   input wire ref_clk,
   input wire rst_b,
   // nonvolatile storage read port, data one cycle after the strobe
   output wire nvm_rd,
   output reg [2:0] nvm_addr,
   input wire [31:0] nvm_rdata,
   // register port
   input wire [ADDR_W-1:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // power state from the power manager, same clock
   input wire sleep_mode,
   // load status
   output reg config_valid,
   // device options
   output reg [15:0] user_identifier,
   output reg low_freq_osc_drive_select,
   // debug
   output reg [2:0] debug_pin_pair_select,
   output reg boundary_scan_port_enable,
   // power supervisor
   output reg brownout_reset_enable,
   output reg low_power_brownout_enable,
   output reg retention_regulator_enable,
   output reg retention_regulator_in_sleep,
   // watchdog
   output reg watchdog_enable,
   output reg wd_clk_low_power_rc,
   output reg wd_clk_fast_rc,
   output reg wd_clk_system,
   output reg [4:0] wd_postscale_exp,
   output reg window_mode_enable,
   output reg [2:0] watchdog_window_eighths
);

   // ----------------------------------------------------------------------
   // load sequencer
   // ----------------------------------------------------------------------
   localparam S_LOAD = 2'h0;
   localparam S_DRAIN = 2'h1;
   localparam S_DECODE = 2'h2;
   localparam S_DONE = 2'h3;

   reg [1:0] state;
   reg [1:0] next_state;
   reg rd_pend;
   reg [2:0] pend_idx;
   reg [31:0] word_mem [0:7];
   integer i;

   // both copies are fetched so software can see whether they agree
   assign nvm_rd = (state == S_LOAD);

   always @* begin
      case (state)
         S_LOAD: begin
            if (nvm_addr == `CWD_IDX_LAST) begin
               next_state = S_DRAIN;
            end else begin
               next_state = S_LOAD;
            end
         end
         S_DRAIN: begin
            if (rd_pend) begin
               next_state = S_DRAIN;
            end else begin
               next_state = S_DECODE;
            end
         end
         S_DECODE: begin
            next_state = S_DONE;
         end
         S_DONE: begin
            next_state = S_DONE;
         end
         default: begin
            next_state = S_LOAD;
         end
      endcase
   end

   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= S_LOAD;
         nvm_addr <= 3'h0;
         rd_pend <= 1'b0;
         pend_idx <= 3'h0;
      end else begin
         state <= next_state;
         rd_pend <= nvm_rd;
         pend_idx <= nvm_addr;
         if (nvm_rd && nvm_addr != `CWD_IDX_LAST) begin
            nvm_addr <= nvm_addr + 3'h1;
         end
      end
   end

   // storage is only written during the load, never by software
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (i = 0; i < 8; i = i + 1) begin
            word_mem[i] <= 32'hffffffff;
         end
      end else if (rd_pend && state != S_DONE) begin
         word_mem[pend_idx] <= nvm_rdata;
      end
   end

   // ----------------------------------------------------------------------
   // primary words and integrity checks
   // ----------------------------------------------------------------------
   wire [31:0] devopt_w = word_mem[`CWD_IDX_DEVOPT];
   wire [31:0] debug_w = word_mem[`CWD_IDX_DEBUG];
   wire [31:0] power_w = word_mem[`CWD_IDX_POWER];
   wire [31:0] wdog_w = word_mem[`CWD_IDX_WDOG];
   wire [1:0] bo_mode = power_w[`CWD_BROWNOUT_HI:`CWD_BROWNOUT_LO];
   wire [1:0] clk_code = wdog_w[`CWD_WD_CLK_HI:`CWD_WD_CLK_LO];
   wire [4:0] run_ps = wdog_w[`CWD_WD_RUN_PS_HI:`CWD_WD_RUN_PS_LO];
   wire [4:0] slp_ps = wdog_w[`CWD_WD_SLP_PS_HI:`CWD_WD_SLP_PS_LO];
   wire [1:0] win_code = wdog_w[`CWD_WD_WIN_HI:`CWD_WD_WIN_LO];

   // a reserved bit left at zero means the part was mis-programmed
   wire rsvd_fault =
      ((devopt_w & `CWD_DEVOPT_RSVD) != `CWD_DEVOPT_RSVD) ||
      ((debug_w & `CWD_DEBUG_RSVD) != `CWD_DEBUG_RSVD) ||
      ((power_w & `CWD_POWER_RSVD) != `CWD_POWER_RSVD) ||
      ((wdog_w & `CWD_WDOG_RSVD) != `CWD_WDOG_RSVD);

   wire copy_mismatch =
      (devopt_w != word_mem[{1'b1, 2'h0}]) ||
      (debug_w != word_mem[{1'b1, 2'h1}]) ||
      (power_w != word_mem[{1'b1, 2'h2}]) ||
      (wdog_w != word_mem[{1'b1, 2'h3}]);

   reg stat_mismatch;
   reg stat_rsvd_fault;
   reg stat_clk_rsvd;

   // ----------------------------------------------------------------------
   // saturating postscale decode
   // ----------------------------------------------------------------------
   function [4:0] ps_exp;
      input [4:0] code;
      begin
         if (code > `CWD_PS_MAX) begin
            ps_exp = `CWD_PS_MAX;
         end else begin
            ps_exp = code;
         end
      end
   endfunction

   // ----------------------------------------------------------------------
   // software control register
   // ----------------------------------------------------------------------
   reg sw_brownout_enable;
   reg runtime_retention_enable;

   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sw_brownout_enable <= 1'b0;
         runtime_retention_enable <= 1'b0;
      end else if (reg_wr && reg_addr == `CWD_OFS_CONTROL) begin
         sw_brownout_enable <= reg_wdata[`CWD_CTRL_SW_BROWNOUT];
         runtime_retention_enable <= reg_wdata[`CWD_CTRL_RETENTION];
      end
   end

   // ----------------------------------------------------------------------
   // options captured once per reset, and the postscale exponent that follows the mode
   // ----------------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         config_valid <= 1'b0;
         user_identifier <= 16'h0000;
         low_freq_osc_drive_select <= 1'b1;
         debug_pin_pair_select <= 3'h0;
         boundary_scan_port_enable <= 1'b0;
         watchdog_enable <= 1'b0;
         wd_postscale_exp <= 5'h00;
         window_mode_enable <= 1'b0;
         watchdog_window_eighths <= `CWD_WIN_75;
         stat_mismatch <= 1'b0;
         stat_rsvd_fault <= 1'b0;
         stat_clk_rsvd <= 1'b0;
      end else if (state == S_DECODE) begin
         config_valid <= 1'b1;
         user_identifier <=
            devopt_w[`CWD_USER_ID_HI:`CWD_USER_ID_LO];
         low_freq_osc_drive_select <= devopt_w[`CWD_OSC_DRIVE];
         case (debug_w[`CWD_DBG_CHAN_HI:`CWD_DBG_CHAN_LO])
            2'h3: begin
               debug_pin_pair_select <= 3'h1;
            end
            2'h2: begin
               debug_pin_pair_select <= 3'h2;
            end
            2'h1: begin
               debug_pin_pair_select <= 3'h4;
            end
            default: begin
               debug_pin_pair_select <= 3'h0;
            end
         endcase
         boundary_scan_port_enable <= debug_w[`CWD_SCAN_EN];
         watchdog_enable <= wdog_w[`CWD_WD_EN];
         window_mode_enable <= ~wdog_w[`CWD_WD_WIN_DIS];
         case (win_code)
            2'h3: begin
               watchdog_window_eighths <= `CWD_WIN_25;
            end
            2'h2: begin
               watchdog_window_eighths <= `CWD_WIN_37;
            end
            2'h1: begin
               watchdog_window_eighths <= `CWD_WIN_50;
            end
            default: begin
               watchdog_window_eighths <= `CWD_WIN_75;
            end
         endcase
         stat_mismatch <= copy_mismatch;
         stat_rsvd_fault <= rsvd_fault;
         stat_clk_rsvd <= (clk_code == `CWD_CLK_RESERVED);
      end else if (state == S_DONE) begin
         // run and sleep counts differ, so the exponent follows the mode
         if (sleep_mode) begin
            wd_postscale_exp <= ps_exp(slp_ps);
         end else begin
            wd_postscale_exp <= ps_exp(run_ps);
         end
      end
   end

   // ----------------------------------------------------------------------
   // mode-dependent options, kept off until the words are loaded
   // ----------------------------------------------------------------------
   reg next_bo;

   always @* begin
      case (bo_mode)
         `CWD_BO_ALWAYS: begin
            next_bo = 1'b1;
         end
         `CWD_BO_AWAKE: begin
            next_bo = ~sleep_mode;
         end
         `CWD_BO_SOFTWARE: begin
            next_bo = sw_brownout_enable;
         end
         default: begin
            next_bo = 1'b0;
         end
      endcase
   end

   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         brownout_reset_enable <= 1'b0;
         low_power_brownout_enable <= 1'b0;
         retention_regulator_enable <= 1'b0;
         retention_regulator_in_sleep <= 1'b0;
         wd_clk_low_power_rc <= 1'b0;
         wd_clk_fast_rc <= 1'b0;
         wd_clk_system <= 1'b0;
      end else if (config_valid) begin
         brownout_reset_enable <= next_bo;
         low_power_brownout_enable <=
            power_w[`CWD_LP_BROWNOUT] & ~next_bo;
         retention_regulator_enable <= ~power_w[`CWD_RET_REG_DIS];
         retention_regulator_in_sleep <= ~power_w[`CWD_RET_REG_DIS] &
            runtime_retention_enable & sleep_mode;
         if (sleep_mode) begin
            wd_clk_low_power_rc <= 1'b1;
            wd_clk_fast_rc <= 1'b0;
            wd_clk_system <= 1'b0;
         end else begin
            // the reserved run code falls back to the system clock
            wd_clk_low_power_rc <=
               (clk_code == `CWD_CLK_LOW_POWER_RC);
            wd_clk_fast_rc <= (clk_code == `CWD_CLK_FAST_RC);
            wd_clk_system <= (clk_code == `CWD_CLK_SYSTEM) ||
               (clk_code == `CWD_CLK_RESERVED);
         end
      end
   end

   // ----------------------------------------------------------------------
   // register read port; config words ignore writes
   // ----------------------------------------------------------------------
   reg [31:0] next_rdata;

   always @* begin
      next_rdata = 32'h00000000;
      case (reg_addr)
         `CWD_OFS_DEVOPT: begin
            next_rdata = devopt_w;
         end
         `CWD_OFS_DEBUG: begin
            next_rdata = debug_w;
         end
         `CWD_OFS_POWER: begin
            next_rdata = power_w;
         end
         `CWD_OFS_WDOG: begin
            next_rdata = wdog_w;
         end
         `CWD_OFS_ALT_DEVOPT: begin
            next_rdata = word_mem[4];
         end
         `CWD_OFS_ALT_DEBUG: begin
            next_rdata = word_mem[5];
         end
         `CWD_OFS_ALT_POWER: begin
            next_rdata = word_mem[6];
         end
         `CWD_OFS_ALT_WDOG: begin
            next_rdata = word_mem[7];
         end
         `CWD_OFS_STATUS: begin
            next_rdata[`CWD_STAT_DONE] = config_valid;
            next_rdata[`CWD_STAT_MISMATCH] = stat_mismatch;
            next_rdata[`CWD_STAT_RSVD_FAULT] = stat_rsvd_fault;
            next_rdata[`CWD_STAT_CLK_RSVD] = stat_clk_rsvd;
         end
         `CWD_OFS_CONTROL: begin
            next_rdata[`CWD_CTRL_SW_BROWNOUT] = sw_brownout_enable;
            next_rdata[`CWD_CTRL_RETENTION] = runtime_retention_enable;
         end
         default: next_rdata = 32'h00000000;
      endcase
   end

   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

endmodule
`default_nettype wire

// [cwd_defines.vh]
// constants for the configuration word option decoder
`ifndef CWD_DEFINES_VH
`define CWD_DEFINES_VH

// ----------------------------------------------------------------------
// word indices in nonvolatile storage (primary 0..3, alternate 4..7)
// ----------------------------------------------------------------------
`define CWD_IDX_DEVOPT 3'h0
`define CWD_IDX_DEBUG 3'h1
`define CWD_IDX_POWER 3'h2
`define CWD_IDX_WDOG 3'h3
`define CWD_IDX_LAST 3'h7
`define CWD_ALT_BIT 2

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define CWD_OFS_DEVOPT 8'h00
`define CWD_OFS_DEBUG 8'h04
`define CWD_OFS_POWER 8'h08
`define CWD_OFS_WDOG 8'h0c
`define CWD_OFS_ALT_DEVOPT 8'h10
`define CWD_OFS_ALT_DEBUG 8'h14
`define CWD_OFS_ALT_POWER 8'h18
`define CWD_OFS_ALT_WDOG 8'h1c
`define CWD_OFS_STATUS 8'h20
`define CWD_OFS_CONTROL 8'h24

// ----------------------------------------------------------------------
// status and control fields
// ----------------------------------------------------------------------
`define CWD_STAT_DONE 0
`define CWD_STAT_MISMATCH 1
`define CWD_STAT_RSVD_FAULT 2
`define CWD_STAT_CLK_RSVD 3
`define CWD_CTRL_SW_BROWNOUT 0
`define CWD_CTRL_RETENTION 1
`define CWD_CTRL_RESET 2'h0

// ----------------------------------------------------------------------
// device options word
// ----------------------------------------------------------------------
`define CWD_USER_ID_HI 31
`define CWD_USER_ID_LO 16
`define CWD_OSC_DRIVE 3
`define CWD_DEVOPT_RSVD 32'h0000fff7

// ----------------------------------------------------------------------
// debug configuration word
// ----------------------------------------------------------------------
`define CWD_DBG_CHAN_HI 4
`define CWD_DBG_CHAN_LO 3
`define CWD_SCAN_EN 2
`define CWD_DEBUG_RSVD 32'hffffffe3

// ----------------------------------------------------------------------
// power-up word
// ----------------------------------------------------------------------
`define CWD_LP_BROWNOUT 3
`define CWD_RET_REG_DIS 2
`define CWD_BROWNOUT_HI 1
`define CWD_BROWNOUT_LO 0
`define CWD_POWER_RSVD 32'hfffffff0
`define CWD_BO_ALWAYS 2'h3
`define CWD_BO_AWAKE 2'h2
`define CWD_BO_SOFTWARE 2'h1
`define CWD_BO_OFF 2'h0

// ----------------------------------------------------------------------
// watchdog word
// ----------------------------------------------------------------------
`define CWD_WD_EN 15
`define CWD_WD_CLK_HI 14
`define CWD_WD_CLK_LO 13
`define CWD_WD_RUN_PS_HI 12
`define CWD_WD_RUN_PS_LO 8
`define CWD_WD_WIN_DIS 7
`define CWD_WD_WIN_HI 6
`define CWD_WD_WIN_LO 5
`define CWD_WD_SLP_PS_HI 4
`define CWD_WD_SLP_PS_LO 0
`define CWD_WDOG_RSVD 32'hffff0000
`define CWD_CLK_LOW_POWER_RC 2'h3
`define CWD_CLK_FAST_RC 2'h2
`define CWD_CLK_RESERVED 2'h1
`define CWD_CLK_SYSTEM 2'h0
`define CWD_PS_MAX 5'h14
`define CWD_WIN_25 3'h2
`define CWD_WIN_37 3'h3
`define CWD_WIN_50 3'h4
`define CWD_WIN_75 3'h6

`endif

// [cwd_option_decoder_sva.sv]
// assertions for the configuration word option decoder
`timescale 1ns/10ps
`default_nettype none
module cwd_option_decoder_sva (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // storage port
   input wire logic nvm_rd,
   input wire logic [2:0] nvm_addr,
   input wire logic [31:0] nvm_rdata,
   // mode input and decoded options
   input wire logic sleep_mode,
   input wire logic config_valid,
   input wire logic [15:0] user_identifier,
   input wire logic low_freq_osc_drive_select,
   input wire logic [2:0] debug_pin_pair_select,
   input wire logic boundary_scan_port_enable,
   input wire logic brownout_reset_enable,
   input wire logic low_power_brownout_enable,
   input wire logic retention_regulator_enable,
   input wire logic watchdog_enable,
   input wire logic wd_clk_low_power_rc,
   input wire logic [4:0] wd_postscale_exp,
   input wire logic window_mode_enable,
   input wire logic [2:0] watchdog_window_eighths
);
   // ---------------------------------------------------------------
   // copies of the primary words as they cross the storage port
   // ---------------------------------------------------------------
   logic rd_q;
   logic [2:0] addr_q;
   logic [31:0] w [0:3];
   always @(posedge ref_clk) begin
      rd_q <= nvm_rd;
      addr_q <= nvm_addr;
      if (rd_q && !addr_q[2]) begin
         w[addr_q[1:0]] <= nvm_rdata;
      end
   end
   function automatic logic [4:0] cwd_sat(input logic [4:0] c);
      cwd_sat = (c > 5'h14) ? 5'h14 : c;
   endfunction
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // mode outputs lag one cycle behind the valid flag
   sequence settled;
      config_valid [*3];
   endsequence
   user_id_a: assert property (settled |-> user_identifier == w[0][31:16])
      else $error("user identifier differs from stored word");
   osc_drive_a: assert property (settled |-> low_freq_osc_drive_select == w[0][3])
      else $error("oscillator drive differs from stored bit");
   dbg_pair_a: assert property (settled |-> debug_pin_pair_select == 3'((4'h8 >> w[1][4:3]) & 4'h7))
      else $error("debug pin pair select wrong");
   scan_en_a: assert property (settled |-> boundary_scan_port_enable == w[1][2])
      else $error("scan port enable wrong");
   bo_always_a: assert property (settled ##0 (w[2][1:0] == 2'h3) |-> brownout_reset_enable)
      else $error("brownout not forced on");
   bo_awake_a: assert property (settled ##0 (w[2][1:0] == 2'h2) |-> brownout_reset_enable == !$past(sleep_mode))
      else $error("brownout does not follow awake state");
   bo_off_a: assert property (settled ##0 (w[2][1:0] == 2'h0) |-> !brownout_reset_enable)
      else $error("brownout on while disabled");
   lp_bo_a: assert property (settled |-> low_power_brownout_enable == (w[2][3] && !brownout_reset_enable))
      else $error("low power brownout wrong");
   ret_reg_a: assert property (settled |-> retention_regulator_enable == !w[2][2])
      else $error("retention regulator enable wrong");
   wd_en_a: assert property (settled |-> watchdog_enable == w[3][15])
      else $error("watchdog enable wrong");
   sleep_clk_a: assert property (settled ##0 $past(sleep_mode) |-> wd_clk_low_power_rc && wd_postscale_exp == cwd_sat(w[3][4:0]))
      else $error("sleep watchdog clock or postscale wrong");
   run_ps_a: assert property (settled ##0 !$past(sleep_mode) |-> wd_postscale_exp == cwd_sat(w[3][12:8]))
      else $error("run postscale wrong");
   window_a: assert property (settled |-> window_mode_enable == !w[3][7] && watchdog_window_eighths == ((w[3][6:5] == 2'h0) ? 3'h6 : 3'h5 - {1'b0, w[3][6:5]}))
      else $error("window decode wrong");
   held_a: assert property (config_valid && $past(config_valid) |-> $stable(user_identifier) && $stable(watchdog_enable))
      else $error("loaded options changed");
endmodule
`default_nettype wire

// [tb.sv]
// self-checking testbench for the configuration word option decoder
`timescale 1ns/10ps
`default_nettype none
`include "cwd_defines.vh"
module tb;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [31:0] nvm_rdata = 32'h0;
   logic [7:0] reg_addr = 8'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sleep_mode = 1'b0;
   wire nvm_rd, config_valid, low_freq_osc_drive_select;
   wire boundary_scan_port_enable, brownout_reset_enable;
   wire low_power_brownout_enable, retention_regulator_enable;
   wire retention_regulator_in_sleep, watchdog_enable, window_mode_enable;
   wire wd_clk_low_power_rc, wd_clk_fast_rc, wd_clk_system;
   wire [2:0] nvm_addr, debug_pin_pair_select, watchdog_window_eighths;
   wire [31:0] reg_rdata;
   wire [15:0] user_identifier;
   wire [4:0] wd_postscale_exp;
   logic [31:0] lfsr = 32'h55;
   logic [31:0] mem [0:7];
   int error_cnt = 0;
   int n_compared = 0;

   cwd_option_decoder cwd_option_decoder_i (.ref_clk, .rst_b, .nvm_rd,
      .nvm_addr, .nvm_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .sleep_mode, .config_valid, .user_identifier,
      .low_freq_osc_drive_select, .debug_pin_pair_select,
      .boundary_scan_port_enable, .brownout_reset_enable,
      .low_power_brownout_enable, .retention_regulator_enable,
      .retention_regulator_in_sleep, .watchdog_enable, .wd_clk_low_power_rc,
      .wd_clk_fast_rc, .wd_clk_system, .wd_postscale_exp,
      .window_mode_enable, .watchdog_window_eighths);

   always #5 ref_clk = ~ref_clk;
   // storage answers one cycle after the strobe, toggles when idle
   always @(posedge ref_clk) begin
      nvm_rdata <= nvm_rd ? mem[nvm_addr] : ~nvm_rdata;
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic cmp(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_check(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      cmp("reg_rdata", e, reg_rdata & m);
   endtask
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // case 8 breaks a reserved bit and the alternate copy
   task automatic load(input int i);
      for (int k = 0; k < 4; k++) begin
         repeat (32) lfsr = lfsr_next(lfsr);
         mem[k] = lfsr;
      end
      mem[0] = mem[0] | `CWD_DEVOPT_RSVD;
      mem[1] = mem[1] | `CWD_DEBUG_RSVD;
      mem[2] = mem[2] | `CWD_POWER_RSVD;
      mem[3] = mem[3] | `CWD_WDOG_RSVD;
      mem[1][4:3] = i[1:0];
      mem[2][1:0] = i[1:0];
      mem[3][14:13] = i[1:0];
      mem[3][6:5] = ~i[1:0];
      mem[3][12:8] = 5'h12 + i[4:0];
      mem[3][4:0] = 5'h10 + 5'(2 * i);
      mem[1][0] = (i != 8);
      for (int k = 0; k < 4; k++) mem[k + 4] = mem[k];
      mem[6][31] = (i != 8);
      sleep_mode <= 1'b0;
      rst_b <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      for (int n = 0; n < 40 && config_valid !== 1'b1; n++) @(posedge ref_clk);
      cmp("config_valid", 1, config_valid);
      repeat (2) @(posedge ref_clk);
   endtask

   // ---------------------------------------------------------------
   // every sleep state and control setting against the model
   // ---------------------------------------------------------------
   task automatic check_modes(input int i);
      logic bo;
      int ps;
      int c;
      for (int m = 0; m < 8; m++) begin
         reg_write(8'h24, 32'(m[1:0]));
         sleep_mode <= m[2];
         repeat (2) @(posedge ref_clk);
         #1;
         c = mem[2][1:0];
         bo = (c == 3) || (c == 2 && !m[2]) || (c == 1 && m[0]);
         c = mem[3][14:13];
         ps = m[2] ? mem[3][4:0] : mem[3][12:8];
         cmp("user_identifier", mem[0][31:16], user_identifier);
         cmp("osc_drive", mem[0][3], low_freq_osc_drive_select);
         cmp("pin_pair", (4'h8 >> mem[1][4:3]) & 4'h7, debug_pin_pair_select);
         cmp("scan_enable", mem[1][2], boundary_scan_port_enable);
         cmp("brownout", bo, brownout_reset_enable);
         cmp("lp_brownout", mem[2][3] & !bo, low_power_brownout_enable);
         cmp("retention", {!mem[2][2], !mem[2][2] & m[1] & m[2]},
            {retention_regulator_enable, retention_regulator_in_sleep});
         cmp("wd_enable", mem[3][15], watchdog_enable);
         cmp("wd_clock", (m[2] || c == 3) ? 4 : (c == 2) ? 2 : 1,
            {wd_clk_low_power_rc, wd_clk_fast_rc, wd_clk_system});
         cmp("postscale", (ps > 20) ? 20 : ps, wd_postscale_exp);
         cmp("window_mode", !mem[3][7], window_mode_enable);
         cmp("window_size", (mem[3][6:5] == 0) ? 6 : 5 - mem[3][6:5],
            watchdog_window_eighths);
      end
      reg_write(8'h00, ~mem[0]);
      for (int k = 0; k < 8; k++) reg_check(8'(4 * k), mem[k], '1);
      reg_check(8'h24, 32'h3, '1);
      reg_check(8'h20, {mem[3][14:13] == 2'h1, i == 8, i == 8, 1'b1}, 32'hf);
      reg_check(8'h28, 32'h0, '1);
   endtask

   task automatic end_sim;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      for (int i = 0; i < 9; i++) begin
         load(i);
         check_modes(i);
      end
      end_sim;
   end
   // about fifteen times the expected run length
   initial begin
      #100000;
      error_cnt++;
      end_sim;
   end
endmodule

bind cwd_option_decoder cwd_option_decoder_sva cwd_option_decoder_sva_i (
   .ref_clk, .rst_b, .nvm_rd, .nvm_addr, .nvm_rdata, .sleep_mode,
   .config_valid, .user_identifier, .low_freq_osc_drive_select,
   .debug_pin_pair_select, .boundary_scan_port_enable,
   .brownout_reset_enable, .low_power_brownout_enable,
   .retention_regulator_enable, .watchdog_enable, .wd_clk_low_power_rc,
   .wd_postscale_exp, .window_mode_enable, .watchdog_window_eighths);
`default_nettype wire
